// ---- design/tpcc_top.sv ----
// Single-channel 16-bit timer with prescaler, capture, compare, PWM and pin routing.
// Assumes an APB master on REF_CLK and asynchronous pins for the clocks and channel.
//
// Notes on behaviour
// R01: In capture mode the channel input comes from port_a_bit5.
// R02: In compare or PWM mode the channel output drives port_a_bit4.
// R03: With the timer disabled both pins stay under plain port control.
// R04: Prescaler divides the selected clock by 1, 2, 4 up to 128.
// R05: 16-bit counter runs free, wraps at modulo, or counts up/down centred.
// R06: Modulo 0x0000 or 0xFFFF gives the full 16-bit free-running range.
// R07: Reading the counter never disturbs the counting sequence.
// R08: Any write to either counter byte clears the counter.
// R09: The channel is capture, compare or buffered edge PWM, independently.
// R10: Capture triggers on rising, falling or either edge.
// R11: A compare match sets, clears or toggles the output pin.
// R12: Software chooses the PWM output polarity.
// R13: Buffered centre-aligned PWM applies to all channels together.
// R14: One request per channel plus one terminal-count request.
// R15: After reset the timer is off and pins are inputs, pullups off.
// R16: Clock select 1:1 drives prescaler and counter from the external pin.
// R17: The external clock is synchronised to the bus clock first.
// R18: The external clock stays below half, ideally a quarter, of bus rate.
// R19: Software sets edge select to 0:0 when the pin is the clock.
// R20: Compare still works as a software timer without any pin action.
// R21: While the timer owns a pin, port data and direction are ignored.
// R22: With no pin function needed the pin returns to port control.
// R23: Clock select 0:0 off, 0:1 bus, 1:0 fixed clock, 1:1 external.
// R24: The 3-bit prescale select follows clock selection for every source.
// R25: Reading one counter byte latches both until the other is read.
// R26: The counter advances only on bus cycles carrying a prescaler tick.
//
// Added by the designer: the APB slave port and the placing of the registers.

`include "tpcc_defs.svh"

module tpcc_top (
	input  wire logic                    REF_CLK,
	input  wire logic                    NRST,
	input  wire tpcc_pkg::tpcc_apb_req_t APB_REQ,
	output logic [31:0]                  PRDATA,
	output logic                         PREADY,
	output logic                         PSLVERR,
	input  wire logic                    FIXED_CLK_IN,
	input  wire logic                    EXT_CLK_IN,
	input  wire logic                    PA4_I,
	output logic                         PA4_O,
	output logic                         PA4_OE,
	input  wire logic                    PA5_I,
	output logic                         PA5_O,
	output logic                         PA5_OE,
	output logic [1:0]                   PULLUP_EN,
	output logic                         IRQ_CHANNEL,
	output logic                         IRQ_OVERFLOW
);
	import tpcc_pkg::*;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic f_rise(input logic now, input logic prev);
		f_rise = now & ~prev;
	endfunction

	function automatic logic [15:0] f_lim(input logic [15:0] m);
		f_lim = (m == 16'h0000) ? `TPCC_FREE_LIM : m;
	endfunction

	function automatic logic [6:0] f_mask(input logic [2:0] s);
		f_mask = 7'((8'h01 << s) - 8'h01);
	endfunction

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	logic        fix_s1_r, fix_s2_r, fix_s3_r;
	logic        ext_s1_r, ext_s2_r, ext_s3_r;
	logic        pa5_s1_r, pa5_s2_r, pa5_s3_r;
	logic        pa4_s1_r, pa4_s2_r;
	logic        toie_r, center_aligned_pwm_r;
	tpcc_clk_t   clks_r;
	logic [2:0]  ps_r;
	logic        chie_r;
	tpcc_mode_t  ms_r;
	logic [1:0]  els_r;
	logic [15:0] mod_r, cnt_r, cv_r, cv_act_r, cnt_buf_r;
	tpcc_dir_t   dir_r;
	logic [6:0]  pre_r;
	logic        ovf_flag_r, ovf_arm_r, ch_flag_r, ch_arm_r;
	logic        cnt_lat_r, lat_hi_r, ch_out_r;
	logic [1:0]  pdat_r, pdir_r, ppul_r;
	logic [31:0] prdata_r;

	// ------------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------------
	wire        setup    = APB_REQ.psel & ~APB_REQ.penable;
	wire        acc      = APB_REQ.psel & APB_REQ.penable;
	wire        wr       = acc & APB_REQ.pwrite;
	wire        rd       = acc & ~APB_REQ.pwrite;
	wire [31:0] wd       = APB_REQ.pwdata;
	wire        sel_sc   = APB_REQ.paddr == `TPCC_SC_OFS;
	wire        sel_cl   = APB_REQ.paddr == `TPCC_CNTL_OFS;
	wire        sel_ch   = APB_REQ.paddr == `TPCC_CNTH_OFS;
	wire        sel_mod  = APB_REQ.paddr == `TPCC_MOD_OFS;
	wire        sel_csc  = APB_REQ.paddr == `TPCC_CSC_OFS;
	wire        sel_cv   = APB_REQ.paddr == `TPCC_CV_OFS;
	wire        sel_pdat = APB_REQ.paddr == `TPCC_PDAT_OFS;
	wire        sel_pdir = APB_REQ.paddr == `TPCC_PDIR_OFS;
	wire        sel_ppul = APB_REQ.paddr == `TPCC_PPUL_OFS;
	wire        hit      = sel_sc | sel_cl | sel_ch | sel_mod | sel_csc | sel_cv
	                     | sel_pdat | sel_pdir | sel_ppul;
	wire        cnt_wr   = wr & (sel_cl | sel_ch);
	wire        sel_cnt  = sel_cl | sel_ch;

	assign PREADY  = 1'b1;
	assign PSLVERR = acc & ~hit;
	assign PRDATA  = prdata_r;

	// ------------------------------------------------------------------
	// Clock source and prescaler
	// ------------------------------------------------------------------
	wire        ten      = clks_r != TPCC_CLK_OFF;
	wire        fix_rise = f_rise(fix_s2_r, fix_s3_r);
	wire        ext_rise = f_rise(ext_s2_r, ext_s3_r);
	wire        src_tick = (clks_r == TPCC_CLK_BUS)                  // see R23
	                     | ((clks_r == TPCC_CLK_FIX) & fix_rise)
	                     | ((clks_r == TPCC_CLK_EXT) & ext_rise);     // see R16
	wire [6:0]  pre_mask = f_mask(ps_r);                              // see R24
	wire        tick     = src_tick & ((pre_r & pre_mask) == pre_mask); // see R04

	// ------------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------------
	wire [15:0] lim      = f_lim(mod_r);                              // see R06
	wire        at_lim   = cnt_r == lim;
	wire [15:0] cnt_inc  = cnt_r + 16'h0001;
	wire [15:0] cnt_dec  = cnt_r - 16'h0001;
	wire        turn_dn  = center_aligned_pwm_r & (dir_r == TPCC_UP) & at_lim;
	wire        turn_up  = center_aligned_pwm_r & (dir_r == TPCC_DOWN) & (cnt_r == 16'h0000);
	wire        go_down  = turn_dn | ((dir_r == TPCC_DOWN) & ~turn_up);
	wire [15:0] cnt_nxt  = ~center_aligned_pwm_r ? (at_lim ? 16'h0000 : cnt_inc)
	                     : (go_down ? cnt_dec : cnt_inc);              // see R05
	wire        ovf_evt  = tick & (center_aligned_pwm_r ? turn_dn : at_lim);         // see R14
	wire [15:0] cnt_view = cnt_lat_r ? cnt_buf_r : cnt_r;

	// ------------------------------------------------------------------
	// Channel
	// ------------------------------------------------------------------
	wire        cap_mode = ~center_aligned_pwm_r & (ms_r == TPCC_MS_CAP);
	wire        cmp_mode = ~center_aligned_pwm_r & (ms_r == TPCC_MS_CMP);
	wire        pwm_mode = center_aligned_pwm_r | ms_r[1];                           // see R13
	wire        pin_use  = ten & (els_r != 2'b00);                     // see R22
	wire        cap_rise = f_rise(pa5_s2_r, pa5_s3_r);
	wire        cap_fall = f_rise(pa5_s3_r, pa5_s2_r);
	wire        cap_evt  = ten & cap_mode
	                     & ((els_r[0] & cap_rise) | (els_r[1] & cap_fall)); // see R10
	wire        match    = tick & (cnt_r == cv_act_r);
	wire        cmp_evt  = ten & cmp_mode & match;                     // see R20
	wire        pwm_on   = pin_use & pwm_mode;
	wire        ch_evt   = cap_evt | cmp_evt | (ten & pwm_mode & match); // see R09
	wire        oc_val   = (els_r == 2'b01) ? ~ch_out_r : els_r[0];    // see R11
	wire        pwm_act  = ~els_r[0];                                  // see R12
	wire        ch_out_nxt = (cmp_evt & pin_use) ? oc_val
	                       : (pwm_on & ~center_aligned_pwm_r & ovf_evt) ? pwm_act
	                       : (pwm_on & match) ? ((center_aligned_pwm_r & (dir_r == TPCC_DOWN)) ? pwm_act
	                                                                       : ~pwm_act)
	                       : ch_out_r;
	wire        cv_load  = ~(ten & pwm_mode) | ovf_evt;

	// ------------------------------------------------------------------
	// Flags
	// ------------------------------------------------------------------
	wire        ovf_clr  = wr & sel_sc & ovf_arm_r & ~wd[`TPCC_SC_FLAG];
	wire        ch_clr   = wr & sel_csc & ch_arm_r & ~wd[`TPCC_CSC_FLAG];

	assign IRQ_OVERFLOW = ovf_flag_r & toie_r;                         // see R14
	assign IRQ_CHANNEL  = ch_flag_r & chie_r;

	// ------------------------------------------------------------------
	// Pin routing
	// ------------------------------------------------------------------
	wire        ch_in_pin  = pin_use & cap_mode;                       // see R01
	wire        ch_out_pin = pin_use & ~cap_mode;                      // see R02

	assign PA4_O     = ch_out_pin ? ch_out_r : pdat_r[0];              // see R21
	assign PA4_OE    = ch_out_pin | pdir_r[0];                         // see R03
	assign PA5_O     = pdat_r[1];
	assign PA5_OE    = ~ch_in_pin & pdir_r[1];                         // see R21
	assign PULLUP_EN = ppul_r;

	// ------------------------------------------------------------------
	// Read data, taken in the setup phase
	// ------------------------------------------------------------------
	wire [31:0] rd_val = sel_sc   ? {24'h000000, ovf_flag_r, toie_r, center_aligned_pwm_r, clks_r, ps_r}
	                   : sel_cl   ? {24'h000000, cnt_view[7:0]}
	                   : sel_ch   ? {24'h000000, cnt_view[15:8]}
	                   : sel_mod  ? {16'h0000, mod_r}
	                   : sel_csc  ? {24'h000000, ch_flag_r, chie_r, ms_r, els_r, 2'h0}
	                   : sel_cv   ? {16'h0000, cv_r}
	                   : sel_pdat ? {30'h00000000, pa5_s2_r, pa4_s2_r}
	                   : sel_pdir ? {30'h00000000, pdir_r}
	                   : sel_ppul ? {30'h00000000, ppul_r}
	                   : 32'h00000000;

	// ------------------------------------------------------------------
	// Synchronisers
	// ------------------------------------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			{fix_s1_r, fix_s2_r, fix_s3_r} <= 3'h0;
			{ext_s1_r, ext_s2_r, ext_s3_r} <= 3'h0;
			{pa5_s1_r, pa5_s2_r, pa5_s3_r} <= 3'h0;
			{pa4_s1_r, pa4_s2_r}           <= 2'h0;
		end else begin
			{fix_s1_r, fix_s2_r, fix_s3_r} <= {FIXED_CLK_IN, fix_s1_r, fix_s2_r};
			{ext_s1_r, ext_s2_r, ext_s3_r} <= {EXT_CLK_IN, ext_s1_r, ext_s2_r}; // see R17
			{pa5_s1_r, pa5_s2_r, pa5_s3_r} <= {PA5_I, pa5_s1_r, pa5_s2_r};
			{pa4_s1_r, pa4_s2_r}           <= {PA4_I, pa4_s1_r};
		end
	end

	// ------------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			{toie_r, center_aligned_pwm_r, ps_r} <= 5'h00;                            // see R15
			clks_r                 <= TPCC_CLK_OFF;
			{chie_r, els_r}        <= 3'h0;
			ms_r                   <= TPCC_MS_CAP;
			mod_r                  <= `TPCC_MOD_RST;
			{pdat_r, pdir_r, ppul_r} <= {`TPCC_PORT_RST, `TPCC_PORT_RST, `TPCC_PORT_RST};
		end else if (wr) begin
			if (sel_sc) begin
				toie_r <= wd[`TPCC_SC_IE];
				center_aligned_pwm_r <= wd[`TPCC_SC_CENTER_ALIGNED_PWM];
				clks_r <= tpcc_clk_t'(wd[`TPCC_SC_CLK_HI:`TPCC_SC_CLK_LO]);
				ps_r   <= wd[`TPCC_SC_PS_HI:`TPCC_SC_PS_LO];
			end
			if (sel_csc) begin
				chie_r <= wd[`TPCC_CSC_IE];
				ms_r   <= tpcc_mode_t'(wd[`TPCC_CSC_MS_HI:`TPCC_CSC_MS_LO]);
				els_r  <= wd[`TPCC_CSC_ELS_HI:`TPCC_CSC_ELS_LO];
			end
			if (sel_mod)  mod_r  <= wd[15:0];
			if (sel_pdat) pdat_r <= wd[1:0];
			if (sel_pdir) pdir_r <= wd[1:0];
			if (sel_ppul) ppul_r <= wd[1:0];
		end
	end

	// ------------------------------------------------------------------
	// Counter, prescaler and read latch
	// ------------------------------------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			cnt_r     <= `TPCC_CNT_RST;
			pre_r     <= `TPCC_PRE_RST;
			dir_r     <= TPCC_UP;
			cnt_buf_r <= `TPCC_CNT_RST;
			cnt_lat_r <= 1'b0;
			lat_hi_r  <= 1'b0;
			prdata_r  <= 32'h00000000;
		end else begin
			if (cnt_wr) begin
				cnt_r <= `TPCC_CNT_RST;                                 // see R08
				pre_r <= `TPCC_PRE_RST;
				dir_r <= TPCC_UP;
			end else begin
				if (src_tick) pre_r <= pre_r + 7'h01;
				if (tick) begin
					cnt_r <= cnt_nxt;                                   // see R26
					dir_r <= turn_dn ? TPCC_DOWN : turn_up ? TPCC_UP : dir_r;
				end
				if (!center_aligned_pwm_r) dir_r <= TPCC_UP;
			end
			if (setup) prdata_r <= rd_val;                              // see R07
			if (cnt_wr | (wr & sel_sc)) begin
				cnt_lat_r <= 1'b0;
			end else if (setup & ~APB_REQ.pwrite & sel_cnt & ~cnt_lat_r) begin
				cnt_buf_r <= cnt_r;                                     // see R25
				cnt_lat_r <= 1'b1;
				lat_hi_r  <= sel_ch;
			end else if (rd & cnt_lat_r & ((lat_hi_r & sel_cl) | (~lat_hi_r & sel_ch))) begin
				cnt_lat_r <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Channel value, output and flags
	// ------------------------------------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			cv_r       <= `TPCC_CV_RST;
			cv_act_r   <= `TPCC_CV_RST;
			ch_out_r   <= 1'b0;
			ovf_flag_r <= 1'b0;
			ovf_arm_r  <= 1'b0;
			ch_flag_r  <= 1'b0;
			ch_arm_r   <= 1'b0;
		end else begin
			if (cap_evt) cv_r <= cnt_r;
			else if (wr & sel_cv) cv_r <= wd[15:0];
			if (cv_load) cv_act_r <= cv_r;
			ch_out_r   <= ch_out_nxt;
			// A new event restarts the clear sequence and wins over the clear.
			ovf_flag_r <= ovf_evt | (ovf_flag_r & ~ovf_clr);
			ovf_arm_r  <= ~ovf_evt & ~(wr & sel_sc) & (ovf_arm_r | (rd & sel_sc & ovf_flag_r));
			ch_flag_r  <= ch_evt | (ch_flag_r & ~ch_clr);
			ch_arm_r   <= ~ch_evt & ~(wr & sel_csc) & (ch_arm_r | (rd & sel_csc & ch_flag_r));
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!NRST);

	sequence s_no_tick;
		(!tick || ps_r != 3'h7) [*8];
	endsequence

	sequence s_turn_point;
		tick && turn_dn && !cnt_wr;
	endsequence

	a_cnt_write_clear: assert property (cnt_wr |=> cnt_r == 16'h0000) // see R08
		else $error("counter not cleared by write");
	a_free_run_wrap: assert property (tick && !center_aligned_pwm_r && !cnt_wr && cnt_r == 16'hFFFF // see R06
		&& (mod_r == 16'h0000 || mod_r == 16'hFFFF) |=> cnt_r == 16'h0000 && ovf_flag_r)
		else $error("free-running counter did not wrap");
	a_modulo_wrap: assert property (tick && !center_aligned_pwm_r && !cnt_wr && mod_r != 16'h0000 // see R05
		&& cnt_r == mod_r |=> cnt_r == 16'h0000)
		else $error("counter did not wrap at modulo");
	a_centre_turn: assert property (s_turn_point |=> dir_r == TPCC_DOWN // see R13
		&& cnt_r == 16'($past(cnt_r) - 16'h0001))
		else $error("centre mode did not turn down");
	a_disabled_hold: assert property (clks_r == TPCC_CLK_OFF && !cnt_wr |=> $stable(cnt_r)) // see R23
		else $error("disabled counter moved");
	a_read_no_disturb: assert property (rd && sel_cnt && !tick |=> $stable(cnt_r)) // see R07
		else $error("counter read changed the count");
	a_cnt_latch: assert property (setup && !APB_REQ.pwrite && sel_cnt && !cnt_lat_r // see R25
		|=> cnt_lat_r && cnt_buf_r == $past(cnt_r))
		else $error("counter bytes not latched");
	a_capture_value: assert property (cap_evt |=> cv_r == $past(cnt_r) && ch_flag_r) // see R10
		else $error("capture missed count value");
	a_oc_toggle: assert property (cmp_evt && els_r == 2'b01 |=> ch_out_r != $past(ch_out_r)) // see R11
		else $error("compare toggle missing");
	a_gpio_when_off: assert property (!ten |-> PA4_OE == pdir_r[0] // see R03
		&& PA5_OE == pdir_r[1] && PA4_O == pdat_r[0])
		else $error("pins not under port control");
	a_prescale_gap: assert property (tick && clks_r == TPCC_CLK_BUS && ps_r == 3'h7 // see R04
		&& !cnt_wr |=> s_no_tick)
		else $error("prescaler ticked too soon");

endmodule

// ---- design/tpcc_defs.svh ----
// Register offsets, field positions, reset values and limits of the timer core.
// Assumes a byte-addressed APB slave with one 32-bit word per register.
`ifndef TPCC_DEFS_SVH
`define TPCC_DEFS_SVH

`define TPCC_SC_OFS      8'h00
`define TPCC_CNTL_OFS    8'h04
`define TPCC_CNTH_OFS    8'h08
`define TPCC_MOD_OFS     8'h0C
`define TPCC_CSC_OFS     8'h10
`define TPCC_CV_OFS      8'h14
`define TPCC_PDAT_OFS    8'h18
`define TPCC_PDIR_OFS    8'h1C
`define TPCC_PPUL_OFS    8'h20

`define TPCC_SC_FLAG     7
`define TPCC_SC_IE       6
`define TPCC_SC_CENTER_ALIGNED_PWM     5
`define TPCC_SC_CLK_HI   4
`define TPCC_SC_CLK_LO   3
`define TPCC_SC_PS_HI    2
`define TPCC_SC_PS_LO    0
`define TPCC_CSC_FLAG    7
`define TPCC_CSC_IE      6
`define TPCC_CSC_MS_HI   5
`define TPCC_CSC_MS_LO   4
`define TPCC_CSC_ELS_HI  3
`define TPCC_CSC_ELS_LO  2

`define TPCC_CNT_RST     16'h0000
`define TPCC_MOD_RST     16'h0000
`define TPCC_CV_RST      16'h0000
`define TPCC_PRE_RST     7'h00
`define TPCC_PORT_RST    2'h0
`define TPCC_FREE_LIM    16'hFFFF

`endif

// ---- design/tpcc_pkg.sv ----
// Types shared by the timer core and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
package tpcc_pkg;

	typedef enum logic [1:0] {
		TPCC_CLK_OFF = 2'b00,
		TPCC_CLK_BUS = 2'b01,
		TPCC_CLK_FIX = 2'b10,
		TPCC_CLK_EXT = 2'b11
	} tpcc_clk_t;

	typedef enum logic [1:0] {
		TPCC_MS_CAP  = 2'b00,
		TPCC_MS_CMP  = 2'b01,
		TPCC_MS_PWM  = 2'b10,
		TPCC_MS_PWM2 = 2'b11
	} tpcc_mode_t;

	typedef enum logic {
		TPCC_UP   = 1'b0,
		TPCC_DOWN = 1'b1
	} tpcc_dir_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} tpcc_apb_req_t;

endpackage

// ---- test/tpcc_pin_model.sv ----
// Pin-side model of the timer core: fixed and external clocks, capture source, loose pins.
// Assumes its tasks are called from processes that run on the bench clock.
module tpcc_pin_model (
	input  wire logic       clk,
	input  wire logic       pa4_o,
	input  wire logic       pa4_oe,
	input  wire logic       pa5_o,
	input  wire logic       pa5_oe,
	input  wire logic [1:0] pullup_en,
	output logic            ext_clk,
	output logic            fix_clk,
	output logic            pa4_i,
	output logic            pa5_i
);
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------
	// Pin levels and clock pulses
	// ----------------------------------------
	logic drv5 = 1'b0;
	logic flt4 = 1'b0;

	initial begin
		ext_clk = 1'b0;
		fix_clk = 1'b0;
	end

	// An undriven pin without pullup wobbles so that a stale level never passes.
	always @(posedge clk) begin
		flt4 <= ~flt4;
	end
	assign pa4_i = pa4_oe ? pa4_o : (pullup_en[0] | flt4);
	assign pa5_i = pa5_oe ? pa5_o : drv5;

	// Pulses are two bus cycles high and two low; both clocks stand still afterwards.
	task automatic pulse(input int nf, input int ne);
		for (int i = 0; i < 2 * ((nf > ne) ? nf : ne); i++) begin
			repeat (2) @(posedge clk);
			if (i < 2 * nf) fix_clk <= ~fix_clk;
			if (i < 2 * ne) ext_clk <= ~ext_clk;
		end
	endtask

	task automatic edge5(input logic lvl);
		@(posedge clk);
		drv5 <= lvl;
	endtask
endmodule

// ---- test/tb_top.sv ----
// Self-checking bench for the timer core: registers, counting, compare, capture and PWM.
// Assumes the design files and the pin model are compiled before it.
`include "tpcc_defs.svh"

module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import tpcc_pkg::*;

	// ----------------------------------------
	// Harness
	// ----------------------------------------
	logic          clk = 1'b0;
	logic          nrst = 1'b0;
	tpcc_apb_req_t req = '0;
	logic [31:0]   prdata, q;
	logic          pready, pslverr, e;
	logic          pa4_o, pa4_oe, pa5_o, pa5_oe, ext_clk, fix_clk, pa4_i, pa5_i;
	logic          irq_ch, irq_ov;
	logic [1:0]    pull;
	logic [31:0]   seed = 32'h114E071F;
	logic [15:0]   v, v0, m, cv;
	logic [1:0]    els [5] = '{2'h3, 2'h1, 2'h3, 2'h2, 2'h0};
	logic [4:0]    po = 5'h15;
	int            n_errors = 0;
	int            n_tests = 0;
	int            cyc = 0;
	int            hi, x;

	tpcc_top i_dut (
		.REF_CLK      (clk),
		.NRST         (nrst),
		.APB_REQ      (req),
		.PRDATA       (prdata),
		.PREADY       (pready),
		.PSLVERR      (pslverr),
		.FIXED_CLK_IN (fix_clk),
		.EXT_CLK_IN   (ext_clk),
		.PA4_I        (pa4_i),
		.PA4_O        (pa4_o),
		.PA4_OE       (pa4_oe),
		.PA5_I        (pa5_i),
		.PA5_O        (pa5_o),
		.PA5_OE       (pa5_oe),
		.PULLUP_EN    (pull),
		.IRQ_CHANNEL  (irq_ch),
		.IRQ_OVERFLOW (irq_ov)
	);

	tpcc_pin_model i_pin (
		.clk       (clk),
		.pa4_o     (pa4_o),
		.pa4_oe    (pa4_oe),
		.pa5_o     (pa5_o),
		.pa5_oe    (pa5_oe),
		.pullup_en (pull),
		.ext_clk   (ext_clk),
		.fix_clk   (fix_clk),
		.pa4_i     (pa4_i),
		.pa5_i     (pa5_i)
	);

	initial forever #50 clk = ~clk;

	task automatic stop_test;
		if (n_errors == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			stop_test();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
	endfunction

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
		@(posedge clk);
		req.penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h00000000);
	endtask

	// The first byte read latches the count; the pair spans six clock edges plus gap.
	task automatic rd_cnt(input logic hf, input int gap);
		logic [7:0] b;
		rd(hf ? `TPCC_CNTH_OFS : `TPCC_CNTL_OFS);
		b = q[7:0];
		repeat (gap) @(posedge clk);
		rd(hf ? `TPCC_CNTL_OFS : `TPCC_CNTH_OFS);
		v = hf ? {b, q[7:0]} : {q[7:0], b};
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		chk({pa4_oe, pa5_oe, pull, irq_ch, irq_ov}, 6'h00);
		for (int k = 0; k < 9; k++) begin
			rd(8'(k * 4 + (k > 5 ? 4 : 0)));
			chk(q, 32'h00000000);
			chk({31'h0, e}, 32'(k == 8));
		end
		rd(8'h24);
		chk(q, 32'h00000000);
		chk({31'h0, e}, 32'h00000001);
		seed = nxt(seed);
		wr(`TPCC_PDIR_OFS, 32'h3);
		wr(`TPCC_PDAT_OFS, seed);
		wr(`TPCC_PPUL_OFS, seed >> 2);
		repeat (2) @(posedge clk);
		chk({pa5_oe, pa5_o, pa4_oe, pa4_o, pull}, {1'b1, seed[1], 1'b1, seed[0], seed[3:2]});
		wr(`TPCC_PPUL_OFS, 32'h0);
		// Clock source and prescaler: the latch edges of two counts lie 128 cycles apart.
		for (int k = 0; k < 12; k++) begin
			wr(`TPCC_SC_OFS, 32'(k < 4 ? k * 8 : 4 + k));
			x = (k == 0) ? 0 : (k == 2) ? 3 : (k == 3) ? 5 : 128 >> (k < 4 ? 0 : k - 4);
			rd_cnt(1'b0, 0);
			v0 = v;
			i_pin.pulse(3, 5);
			repeat (102) @(posedge clk);
			rd_cnt(k[0], 300);
			chk(16'(v - v0), 32'(x));
		end
		wr(`TPCC_CNTH_OFS, seed);
		rd_cnt(1'b0, 0);
		chk(v < 16'h0004, 1);
		// Compare actions; port data stays 1 so that a stolen pin shows.
		wr(`TPCC_PDAT_OFS, 32'h3);
		wr(`TPCC_SC_OFS, 32'h08);
		wr(`TPCC_CV_OFS, 32'h40);
		for (int k = 0; k < 5; k++) begin
			wr(`TPCC_CNTL_OFS, seed);
			wr(`TPCC_CSC_OFS, {26'h5, els[k], 2'h0});
			repeat (100) @(posedge clk);
			chk({pa4_oe, pa4_o}, {1'b1, po[k]});
			rd(`TPCC_CSC_OFS);
			chk({irq_ch, q[7]}, 2'h3);
		end
		// Capture edges on the second pin, which the port may not drive meanwhile.
		for (int k = 1; k < 4; k++) begin
			wr(`TPCC_CSC_OFS, 32'(k * 4));
			for (int s = 0; s < 2; s++) begin
				i_pin.edge5(s == 0);
				repeat (6) @(posedge clk);
				rd(`TPCC_CSC_OFS);
				chk({pa5_oe, q[7]}, {1'b0, s ? k[1] : k[0]});
				wr(`TPCC_CSC_OFS, 32'(k * 4));
			end
		end
		// Modulo limit in up and in centre mode, then the overflow clear sequence.
		seed = nxt(seed);
		m = 16'h5 + seed[3:0];
		wr(`TPCC_MOD_OFS, m);
		for (int c = 0; c < 2; c++) begin
			wr(`TPCC_SC_OFS, 32'(8'h48 | (c << 5)));
			wr(`TPCC_CNTL_OFS, 32'h0);
			repeat (40) @(posedge clk);
			for (int k = 0; k < 4; k++) begin
				rd_cnt(k[0], k * 3);
				chk(v <= m, 1);
			end
			// Stop the count first so that no new overflow restarts the clear sequence.
			wr(`TPCC_SC_OFS, 32'(8'h40 | (c << 5)));
			rd(`TPCC_SC_OFS);
			chk({irq_ov, q[7]}, 2'h3);
			wr(`TPCC_SC_OFS, 32'(8'h40 | (c << 5)));
			rd(`TPCC_SC_OFS);
			chk({irq_ov, q[7:0]}, 32'(8'h40 | (c << 5)));
		end
		// Edge PWM over one 100-cycle period in both polarities.
		wr(`TPCC_MOD_OFS, 32'd99);
		wr(`TPCC_SC_OFS, 32'h08);
		seed = nxt(seed);
		cv = 16'hA + seed[5:0];
		for (int p = 0; p < 2; p++) begin
			wr(`TPCC_CSC_OFS, 32'h0);
			wr(`TPCC_CV_OFS, cv);
			wr(`TPCC_CSC_OFS, p ? 32'h24 : 32'h28);
			repeat (250) @(posedge clk);
			hi = 0;
			repeat (100) begin
				@(posedge clk);
				hi += (pa4_o === 1'b1 && pa4_oe === 1'b1);
			end
			chk(hi, p ? 99 - cv : cv + 1);
		end
		stop_test();
	end
endmodule
